// ==== imux_consts.vh ====
// Constants for the indicator pin function multiplexer: register indices,
// field positions, reset values and function codes.
// Assumes a Wishbone slave with 32-bit data; each register is one word.
`ifndef IMUX_CONSTS_VH
`define IMUX_CONSTS_VH

// Register indices; the byte address is four times the index.
`define IMUX_IDX_IO_CFG        10'h302
`define IMUX_IDX_PIN1_CFG      10'h304
`define IMUX_IDX_PIN2_CFG      10'h305
`define IMUX_IDX_PIN3_CFG      10'h306
`define IMUX_IDX_PIN_STATUS    10'h308

// Field positions.
`define IMUX_FUNC_MSB          2
`define IMUX_FUNC_LSB          0
`define IMUX_CLKSEL_MSB        5
`define IMUX_CLKSEL_LSB        3
`define IMUX_CLK_DISABLE_BIT   6
`define IMUX_STATUS_BIT        0

// Reset values and the writable-bit mask of the IO config register.
`define IMUX_IO_CFG_RST        16'h0000
`define IMUX_IO_CFG_WMASK      16'hffc0
`define IMUX_PIN_CFG_RST       16'h0008
`define IMUX_STATUS_RST        16'h0002
`define IMUX_CLKSEL_RST        3'h1
`define IMUX_FUNC_RST          3'h0

// Function and clock source codes.
`define IMUX_FUNC_CLOCK        3'h1
`define IMUX_FUNC_REF_CLOCK    3'h6
`define IMUX_CLKSEL_PLL        3'h5
`define IMUX_CLKSEL_RECOVERED  3'h6

// Cycles after reset release before straps are sampled (sync depth).
`define IMUX_STRAP_WAIT        2'h2

`endif

// ==== imux_pin_sel.v ====
// One pin's function selector: picks one of eight candidate sources.
// Assumes the caller has already placed each source at its code position.
`timescale 1ns/1ps
module imux_pin_sel (
	input  wire [2:0] code,
	input  wire [7:0] src,
	output wire       sel_out
);
	assign sel_out = src[code];
endmodule // imux_pin_sel

// ==== imux_top.v ====
// Indicator pin function multiplexer with its Wishbone register file.
// Assumes indicator, wake, interrupt, collision, carrier sense and transmit
// error come from logic on mclk; clocks and straps arrive asynchronously.
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
`include "imux_consts.vh"
module imux_top (
	input  wire        mclk,
	input  wire        rstn,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [11:0] wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire        ind1_function,
	input  wire        ind2_function,
	input  wire        ind3_function,
	input  wire        wake_event,
	input  wire        interrupt_req,
	input  wire        collision,
	input  wire        carrier_sense,
	input  wire        tx_error,
	input  wire        pll_clock,
	input  wire        recovered_clock,
	input  wire        reference_clock_25mhz,
	input  wire        extended_mode_strap,
	input  wire        shared_pin_clock_strap,
	output reg         indicator_pin_1,
	output reg         indicator_pin_2,
	output reg         indicator_pin_3
);

	reg        rst_meta_q;
	reg        rst_sync_q;
	wire       rst_n;
	reg  [4:0] meta_q;
	reg  [4:0] sync_q;
	reg  [1:0] strap_cnt_q;
	reg        strap_done_q;
	reg        ext_mode_q;
	reg  [2:0] pin1_function_select_q;
	reg  [2:0] pin1_clock_source_select_q;
	reg  [2:0] pin2_function_select_q;
	wire [2:0] pin3_function_select;
	reg  [15:0] io_cfg_q;
	wire       shared_pin_clock_disable;
	wire       shared_pin_clock_disabled_status;
	wire [9:0] reg_idx;
	wire       req;
	wire       wr_en;
	reg  [15:0] rd_data;
	wire       pll_s;
	wire       rec_s;
	wire       ref_s;
	wire       ext_strap_s;
	wire       clk_strap_s;
	reg        pin1_clock;
	wire [7:0] pin1_src;
	wire [7:0] pin2_src;
	wire [7:0] pin3_src;
	wire       pin1_sel;
	wire       pin2_sel;
	wire       pin3_sel;
	wire       pin1_d;

	// Reset is asserted at once but released only through two flops.
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	assign rst_n = rst_sync_q;

	// Clocks are sampled as levels at 10 MHz, so a routed clock is only a
	// coarse image of the real one; a pad-level bypass would be needed for
	// a clean waveform.
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 5'h00;
			sync_q <= 5'h00;
		end else begin
			meta_q <= {shared_pin_clock_strap, extended_mode_strap,
				reference_clock_25mhz, recovered_clock, pll_clock};
			sync_q <= meta_q;
		end
	end
	assign pll_s       = sync_q[0];
	assign rec_s       = sync_q[1];
	assign ref_s       = sync_q[2];
	assign ext_strap_s = sync_q[3];
	assign clk_strap_s = sync_q[4];

	// Wishbone decode; one wait state, ack dropped the cycle after it.
	assign reg_idx = wb_adr_i[11:2];
	assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_en   = req & wb_we_i;

	assign shared_pin_clock_disable = io_cfg_q[`IMUX_CLK_DISABLE_BIT];
	// Status follows the choice only in extended mode.
	assign shared_pin_clock_disabled_status =
		ext_mode_q & shared_pin_clock_disable;

	// Straps are caught once, after the synchronisers have filled.
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			strap_cnt_q                <= 2'h0;
			strap_done_q               <= 1'b0;
			ext_mode_q                 <= 1'b0;
			pin1_function_select_q     <= `IMUX_FUNC_RST;
			pin1_clock_source_select_q <= `IMUX_CLKSEL_RST;
			pin2_function_select_q     <= `IMUX_FUNC_RST;
			io_cfg_q                   <= `IMUX_IO_CFG_RST;
		end else if (!strap_done_q) begin
			strap_cnt_q <= strap_cnt_q + 2'h1;
			if (strap_cnt_q == `IMUX_STRAP_WAIT) begin
				strap_done_q <= 1'b1;
				ext_mode_q   <= ext_strap_s;
				if (ext_strap_s && clk_strap_s) begin
					pin1_function_select_q <= `IMUX_FUNC_REF_CLOCK;
					io_cfg_q[`IMUX_CLK_DISABLE_BIT] <= 1'b0;
				end else if (ext_strap_s) begin
					pin1_function_select_q <= `IMUX_FUNC_RST;
					io_cfg_q[`IMUX_CLK_DISABLE_BIT] <= 1'b1;
				end
			end
		end else if (wr_en) begin
			case (reg_idx)
			`IMUX_IDX_IO_CFG: begin
				if (wb_sel_i[0])
					io_cfg_q[7:6] <= wb_dat_i[7:6];
				if (wb_sel_i[1])
					io_cfg_q[15:8] <= wb_dat_i[15:8];
			end
			`IMUX_IDX_PIN1_CFG: begin
				if (wb_sel_i[0]) begin
					pin1_function_select_q <=
						wb_dat_i[`IMUX_FUNC_MSB:`IMUX_FUNC_LSB];
					pin1_clock_source_select_q <=
						wb_dat_i[`IMUX_CLKSEL_MSB:`IMUX_CLKSEL_LSB];
				end
			end
			`IMUX_IDX_PIN2_CFG: begin
				if (wb_sel_i[0])
					pin2_function_select_q <=
						wb_dat_i[`IMUX_FUNC_MSB:`IMUX_FUNC_LSB];
			end
			default: begin
				// Pin 3 and status are read-only; others are unmapped.
			end
			endcase
		end
	end

	// Pin 3 function is fixed at its reset code; a continuous assignment
	// is used because a process that reads nothing would never run.
	assign pin3_function_select = `IMUX_FUNC_RST;

	// Reserved fields read back their reset values.
	always @* begin
		rd_data = 16'h0000;
		case (reg_idx)
		`IMUX_IDX_IO_CFG:
			rd_data = io_cfg_q & `IMUX_IO_CFG_WMASK;
		`IMUX_IDX_PIN1_CFG:
			rd_data = {10'h000, pin1_clock_source_select_q,
				pin1_function_select_q};
		`IMUX_IDX_PIN2_CFG:
			rd_data = {10'h000, `IMUX_CLKSEL_RST,
				pin2_function_select_q};
		`IMUX_IDX_PIN3_CFG:
			rd_data = {10'h000, `IMUX_CLKSEL_RST,
				pin3_function_select};
		`IMUX_IDX_PIN_STATUS:
			rd_data = `IMUX_STATUS_RST |
				{15'h0000, shared_pin_clock_disabled_status};
		default:
			rd_data = 16'h0000;
		endcase
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= req;
			if (req && !wb_we_i)
				wb_dat_o <= {16'h0000, rd_data};
		end
	end

	// Clock source for pin 1 code 1; reserved selections drive low.
	always @* begin
		case (pin1_clock_source_select_q)
		`IMUX_CLKSEL_PLL:       pin1_clock = pll_s;
		`IMUX_CLKSEL_RECOVERED: pin1_clock = rec_s;
		default:                pin1_clock = 1'b0;
		endcase
	end

	// Source vectors, indexed by function code.
	assign pin1_src = {1'b0, ref_s, tx_error, interrupt_req, 1'b0,
		wake_event, pin1_clock, ind1_function};
	assign pin2_src = {1'b1, collision, collision, interrupt_req,
		collision, wake_event, 1'b0, ind2_function};
	assign pin3_src = {1'b1, carrier_sense, carrier_sense, interrupt_req,
		carrier_sense, wake_event, 1'b0, ind3_function};

	imux_pin_sel u_pin1 (
		.code    (pin1_function_select_q),
		.src     (pin1_src),
		.sel_out (pin1_sel)
	);
	imux_pin_sel u_pin2 (
		.code    (pin2_function_select_q),
		.src     (pin2_src),
		.sel_out (pin2_sel)
	);
	imux_pin_sel u_pin3 (
		.code    (pin3_function_select),
		.src     (pin3_src),
		.sel_out (pin3_sel)
	);

	// In extended mode the shared pin carries the 25 MHz clock unless
	// software or a low shared pin clock strap hands it to the pin 1 function.
	assign pin1_d = (ext_mode_q && !shared_pin_clock_disable) ?
		ref_s : pin1_sel;

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			indicator_pin_1 <= 1'b0;
			indicator_pin_2 <= 1'b0;
			indicator_pin_3 <= 1'b0;
		end else begin
			indicator_pin_1 <= pin1_d;
			indicator_pin_2 <= pin2_sel;
			indicator_pin_3 <= pin3_sel;
		end
	end

endmodule // imux_top

// ==== imux_chk_sva.sv ====
// Bus and pin timing checks for the indicator pin function multiplexer.
// Assumes it is bound to imux_top and sees only that module's ports.
`timescale 1ns/1ps
module imux_chk (
	input wire        mclk,
	input wire        rstn,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire [11:0] wb_adr_i,
	input wire [3:0]  wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	input wire        ind3_function,
	input wire        indicator_pin_2,
	input wire        indicator_pin_3
);
	wire req = wb_cyc_i & wb_stb_i & !wb_ack_o;
	wire rd = req & !wb_we_i;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	ack_answer_a: assert property (req |=> wb_ack_o)
		else $error("ack missing");
	pin2_high_a: assert property (req && wb_we_i && wb_sel_i[0] &&
		wb_adr_i == 12'hc14 && wb_dat_i[2:0] == 3'h7 |-> ##2 indicator_pin_2)
		else $error("pin 2 not high");
	// Five high samples keep the check clear of the internal reset delay.
	pin3_follow_a: assert property (rstn[*5] |->
		indicator_pin_3 == $past(ind3_function))
		else $error("pin 3 not indicator");
	pin3_fixed_a: assert property (rd && wb_adr_i == 12'hc18 |=>
		wb_dat_o[15:0] == 16'h0008) else $error("pin 3 config moved");
	status_rsv_a: assert property (rd && wb_adr_i == 12'hc20 |=>
		wb_dat_o[15:1] == 15'h1) else $error("status reserved bits");
	pin2_rsv_a: assert property (rd && wb_adr_i == 12'hc14 |=>
		wb_dat_o[15:3] == 13'h1) else $error("pin 2 reserved bits");
	unmapped_zero_a: assert property (rd && wb_adr_i == 12'h000 |=>
		wb_dat_o == 32'h0) else $error("unmapped read not zero");
endmodule // imux_chk
bind imux_top imux_chk u_chk (.mclk(mclk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .ind3_function(ind3_function),
	.indicator_pin_2(indicator_pin_2), .indicator_pin_3(indicator_pin_3));

// ==== imux_tb.sv ====
// Self-checking bench for the indicator pin function multiplexer.
// Starts with both straps high, then resets again with other strap settings.
`timescale 1ns/1ps
module testbench;
	logic        mclk = 1'b0;
	logic        rstn = 1'b0;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic [11:0] adr = 12'h0;
	logic [31:0] wdat = 32'h0;
	logic [10:0] src = 11'h0;
	logic        ext_strap = 1'b1;
	logic        clk_strap = 1'b1;
	logic [31:0] q;
	wire  [31:0] rdat;
	wire         ack;
	wire  [2:0]  pins;
	int          mismatches = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	imux_top dut (.mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .ind1_function(src[0]),
		.ind2_function(src[1]), .ind3_function(src[2]),
		.wake_event(src[3]), .interrupt_req(src[4]), .collision(src[5]),
		.carrier_sense(src[6]), .tx_error(src[7]), .pll_clock(src[8]),
		.recovered_clock(src[9]), .reference_clock_25mhz(src[10]),
		.extended_mode_strap(ext_strap), .shared_pin_clock_strap(clk_strap),
		.indicator_pin_1(pins[0]), .indicator_pin_2(pins[1]),
		.indicator_pin_3(pins[2]));
	initial forever #50 mclk = ~mclk;
	task automatic complete_run();
		if (mismatches == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			complete_run();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge mclk); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	// The pin must show the masked source alone, then ignore all the others.
	task automatic route(input logic [11:0] a, input logic [15:0] v,
		input logic [10:0] m, input logic p1, input logic p0, input int k);
		wb(1'b1, a, {16'h0, v});
		src <= m;
		repeat (5) @(posedge mclk);
		chk({31'h0, pins[k]}, {31'h0, p1});
		src <= ~m;
		repeat (5) @(posedge mclk);
		chk({31'h0, pins[k]}, {31'h0, p0});
	endtask
	task automatic t_reset();
		rd(12'hc10, 32'h000e);
		rd(12'hc14, 32'h0008);
		rd(12'hc08, 32'h0000);
		rd(12'h000, 32'h0);
		route(12'hc20, 16'hffff, 11'h400, 1'b1, 1'b0, 0);
		rd(12'hc20, 32'h0002);
	endtask
	task automatic t_pin1();
		wb(1'b1, 12'hc08, 32'h0040);
		rd(12'hc20, 32'h0003);
		route(12'hc10, 16'h0008, 11'h001, 1'b1, 1'b0, 0);
		route(12'hc10, 16'h000a, 11'h008, 1'b1, 1'b0, 0);
		route(12'hc10, 16'h000c, 11'h010, 1'b1, 1'b0, 0);
		route(12'hc10, 16'h000d, 11'h080, 1'b1, 1'b0, 0);
		route(12'hc10, 16'h000e, 11'h400, 1'b1, 1'b0, 0);
		route(12'hc10, 16'h0029, 11'h100, 1'b1, 1'b0, 0);
		route(12'hc10, 16'h0031, 11'h200, 1'b1, 1'b0, 0);
		route(12'hc10, 16'h0001, 11'h300, 1'b0, 1'b0, 0);
		route(12'hc10, 16'hffcb, 11'h000, 1'b0, 1'b0, 0);
		rd(12'hc10, 32'h000b);
		route(12'hc10, 16'h000f, 11'h000, 1'b0, 1'b0, 0);
	endtask
	task automatic t_pin2();
		route(12'hc14, 16'h0008, 11'h002, 1'b1, 1'b0, 1);
		route(12'hc14, 16'h000a, 11'h008, 1'b1, 1'b0, 1);
		route(12'hc14, 16'h000c, 11'h010, 1'b1, 1'b0, 1);
		route(12'hc14, 16'h000b, 11'h020, 1'b1, 1'b0, 1);
		route(12'hc14, 16'h000d, 11'h020, 1'b1, 1'b0, 1);
		route(12'hc14, 16'h000e, 11'h020, 1'b1, 1'b0, 1);
		route(12'hc14, 16'h0009, 11'h000, 1'b0, 1'b0, 1);
		route(12'hc14, 16'hffff, 11'h000, 1'b1, 1'b1, 1);
		rd(12'hc14, 32'h000f);
	endtask
	task automatic t_pin3();
		route(12'hc18, 16'h0007, 11'h004, 1'b1, 1'b0, 2);
		rd(12'hc18, 32'h0008);
	endtask
	// Reset again with new straps; pin 1 must start on its own function.
	task automatic t_strap(input logic x, input logic c,
		input logic [31:0] p1e, input logic [31:0] ste);
		rstn <= 1'b0;
		ext_strap <= x;
		clk_strap <= c;
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		repeat (8) @(posedge mclk);
		rd(12'hc10, p1e);
		rd(12'hc20, ste);
		route(12'hc10, 16'h0008, 11'h001, 1'b1, 1'b0, 0);
		wb(1'b1, 12'hc08, 32'h0040);
		rd(12'hc20, {30'h0, 1'b1, x});
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		repeat (8) @(posedge mclk);
		t_reset();
		t_pin1();
		t_pin2();
		t_pin3();
		t_strap(1'b0, 1'b0, 32'h0008, 32'h0002);
		t_strap(1'b1, 1'b0, 32'h0008, 32'h0003);
		complete_run();
	end
endmodule // testbench
